// [verilog/pcm_cfg.svh]
// constants of the abc pulse counter core
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH
`define PCM_CNT_W 32
`define PCM_ZERO 32'h0000_0000
`define PCM_ONE 32'h0000_0001
`define PCM_SYNC_RST 3'h0
`define PCM_CLK_HZ 50000000
`endif

// [verilog/pcm_pkg.sv]
// types of the abc pulse counter core
package pcm_pkg;
  // a and b counting modes
  typedef enum logic [2:0] {
    PCM_AB_X1 = 3'b000,
    PCM_AB_X2 = 3'b001,
    PCM_AB_X4 = 3'b010,
    PCM_AB_SUM = 3'b011,
    PCM_AB_DIFF = 3'b100,
    PCM_AB_INDEP = 3'b101,
    PCM_AB_CNTDIR = 3'b110
  } pcm_ab_e;
  // c control functions
  typedef enum logic [1:0] {
    PCM_C_NONE = 2'b00,
    PCM_C_CAPTURE = 2'b01,
    PCM_C_GATE = 2'b10,
    PCM_C_COUNT = 2'b11
  } pcm_c_e;
  // one mode setting selects both functions
  typedef struct packed {
    pcm_ab_e ab;
    pcm_c_e c;
  } pcm_mode_s;
  typedef struct packed {
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic c_rise;
    logic c_fall;
    logic a_lvl;
    logic b_lvl;
  } pcm_edge_s;
  typedef struct packed {
    logic [31:0] pri;
    logic [31:0] sec;
    logic [31:0] ccnt;
  } pcm_cnt_s;
endpackage

// [verilog/pcm_edge_sync.sv]
// three-stage input synchroniser and edge detector for a, b, c
`timescale 1ns/100ps
`include "pcm_cfg.svh"
module pcm_edge_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] pins,
  output pcm_pkg::pcm_edge_s edges
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } pcm_sync_s;
  pcm_sync_s st_q;
  pcm_sync_s st_d;

  // ------------------------------------------------------------
  // sampling chain
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= {`PCM_SYNC_RST, `PCM_SYNC_RST, `PCM_SYNC_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // one pulse per edge
  // an edge counts once stage two and three disagree; stage one is never read here
  always_comb begin
    edges.a_rise = st_q.s2[0] & ~st_q.s3[0];
    edges.a_fall = ~st_q.s2[0] & st_q.s3[0];
    edges.b_rise = st_q.s2[1] & ~st_q.s3[1];
    edges.b_fall = ~st_q.s2[1] & st_q.s3[1];
    edges.c_rise = st_q.s2[2] & ~st_q.s3[2];
    edges.c_fall = ~st_q.s2[2] & st_q.s3[2];
    edges.a_lvl = st_q.s3[0];
    edges.b_lvl = st_q.s3[1];
  end
endmodule // pcm_edge_sync

// [verilog/pcm_counter.sv]
// abc pulse counter core: quadrature, combined and independent counting with c control
// Function
// - a lagging b counts up
// - x1 counts on a edges, b low
// - x2 counts on both a edges
// - x4 counts on every a, b edge
// - sum mode adds both rising edges
// - difference mode adds a, subtracts b
// - independent mode, b counts secondary
// - a counts, b gives direction
// - c falling edge captures both counters
// - capture leaves counters running
// - primary gate holds count since last c
// - secondary gate holds count since last c
// - gate update never clears counters
// - secondary gate only in independent mode
// - c functions run beside ab counting
// - one mode setting selects both functions
// - c count mode counts c pulses
`timescale 1ns/100ps
`include "pcm_cfg.svh"
module pcm_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic pin_c,
  input pcm_pkg::pcm_mode_s mode,
  output pcm_pkg::pcm_cnt_s counts,
  output logic [`PCM_CNT_W-1:0] cap_pri,
  output logic [`PCM_CNT_W-1:0] cap_sec,
  output logic [`PCM_CNT_W-1:0] gate_pri,
  output logic [`PCM_CNT_W-1:0] gate_sec
);
  typedef struct packed {
    pcm_pkg::pcm_cnt_s cnt;
    logic [`PCM_CNT_W-1:0] cap_pri;
    logic [`PCM_CNT_W-1:0] cap_sec;
    logic [`PCM_CNT_W-1:0] gate_pri;
    logic [`PCM_CNT_W-1:0] gate_sec;
    logic [`PCM_CNT_W-1:0] prev_pri;
    logic [`PCM_CNT_W-1:0] prev_sec;
  } pcm_state_s;

  pcm_state_s st_q;
  pcm_state_s st_d;
  pcm_pkg::pcm_edge_s ed;
  logic pri_up;
  logic pri_dn;
  logic pri_up2;
  logic sec_up;

  pcm_edge_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pins({pin_c, pin_b, pin_a}),
    .edges(ed)
  );

  // ------------------------------------------------------------
  // count decode per mode
  // ------------------------------------------------------------
  // in sum and difference modes a and b edges may land in the same cycle,
  // so two separate step terms keep both counts
  always_comb begin
    pri_up = 1'b0;
    pri_dn = 1'b0;
    pri_up2 = 1'b0;
    sec_up = 1'b0;
    case (mode.ab)
      pcm_pkg::PCM_AB_X1: begin
        pri_dn = ed.a_rise & ~ed.b_lvl;
        pri_up = ed.a_fall & ~ed.b_lvl;
      end
      pcm_pkg::PCM_AB_X2: begin
        pri_dn = (ed.a_rise & ~ed.b_lvl) | (ed.a_fall & ed.b_lvl);
        pri_up = (ed.a_rise & ed.b_lvl) | (ed.a_fall & ~ed.b_lvl);
      end
      pcm_pkg::PCM_AB_X4: begin
        pri_dn = (ed.a_rise & ~ed.b_lvl) | (ed.b_rise & ed.a_lvl)
               | (ed.a_fall & ed.b_lvl) | (ed.b_fall & ~ed.a_lvl);
        pri_up = (ed.a_rise & ed.b_lvl) | (ed.b_rise & ~ed.a_lvl)
               | (ed.a_fall & ~ed.b_lvl) | (ed.b_fall & ed.a_lvl);
      end
      pcm_pkg::PCM_AB_SUM: begin
        pri_up = ed.a_rise;
        pri_up2 = ed.b_rise;
      end
      pcm_pkg::PCM_AB_DIFF: begin
        pri_up = ed.a_rise;
        pri_dn = ed.b_rise;
      end
      pcm_pkg::PCM_AB_INDEP: begin
        pri_up = ed.a_rise;
        sec_up = ed.b_rise;
      end
      pcm_pkg::PCM_AB_CNTDIR: begin
        pri_up = ed.a_rise & ~ed.b_lvl;
        pri_dn = ed.a_rise & ed.b_lvl;
      end
      default: begin
        pri_up = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.cnt.pri = st_q.cnt.pri + (pri_up ? `PCM_ONE : `PCM_ZERO)
                 + (pri_up2 ? `PCM_ONE : `PCM_ZERO) - (pri_dn ? `PCM_ONE : `PCM_ZERO);
    st_d.cnt.sec = st_q.cnt.sec + (sec_up ? `PCM_ONE : `PCM_ZERO);
    if (mode.c == pcm_pkg::PCM_C_COUNT && ed.c_rise) begin
      st_d.cnt.ccnt = st_q.cnt.ccnt + `PCM_ONE;
    end
    case (mode.c)
      pcm_pkg::PCM_C_CAPTURE: begin
        if (ed.c_fall) begin
          st_d.cap_pri = st_q.cnt.pri;
          st_d.cap_sec = st_q.cnt.sec;
        end
      end
      pcm_pkg::PCM_C_GATE: begin
        if (ed.c_fall) begin
          st_d.gate_pri = st_q.cnt.pri - st_q.prev_pri;
          st_d.prev_pri = st_q.cnt.pri;
          if (mode.ab == pcm_pkg::PCM_AB_INDEP) begin
            st_d.gate_sec = st_q.cnt.sec - st_q.prev_sec;
          end
          st_d.prev_sec = st_q.cnt.sec;
        end
      end
      default: begin
        st_d.prev_pri = st_q.prev_pri;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign counts = st_q.cnt;
  assign cap_pri = st_q.cap_pri;
  assign cap_sec = st_q.cap_sec;
  assign gate_pri = st_q.gate_pri;
  assign gate_sec = st_q.gate_sec;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_x1_down_step: assert property (
    mode.ab == pcm_pkg::PCM_AB_X1 && $stable(mode) && ed.a_rise && !ed.b_lvl
    |=> st_q.cnt.pri == $past(st_q.cnt.pri) - `PCM_ONE)
    else $error("x1 rising a with b low did not decrement");
  a_x2_up_step: assert property (
    mode.ab == pcm_pkg::PCM_AB_X2 && ed.a_fall && !ed.b_lvl
    |=> st_q.cnt.pri == $past(st_q.cnt.pri) + `PCM_ONE)
    else $error("x2 falling a with b low did not increment");
  a_x4_b_rise: assert property (
    mode.ab == pcm_pkg::PCM_AB_X4 && ed.b_rise && ed.a_lvl
    |=> st_q.cnt.pri == $past(st_q.cnt.pri) - `PCM_ONE)
    else $error("x4 rising b with a high did not decrement");
  a_sum_both: assert property (
    mode.ab == pcm_pkg::PCM_AB_SUM && ed.a_rise && ed.b_rise
    |=> st_q.cnt.pri == $past(st_q.cnt.pri) + `PCM_ONE + `PCM_ONE)
    else $error("sum mode lost a coincident edge");
  a_diff_b_dn: assert property (
    mode.ab == pcm_pkg::PCM_AB_DIFF && ed.b_rise && !ed.a_rise
    |=> st_q.cnt.pri == $past(st_q.cnt.pri) - `PCM_ONE)
    else $error("difference mode b edge did not decrement");
  a_indep_sec: assert property (
    mode.ab == pcm_pkg::PCM_AB_INDEP && ed.b_rise
    |=> st_q.cnt.sec == $past(st_q.cnt.sec) + `PCM_ONE)
    else $error("independent b edge did not count secondary");
  a_cntdir_dn: assert property (
    mode.ab == pcm_pkg::PCM_AB_CNTDIR && ed.a_rise && ed.b_lvl
    |=> st_q.cnt.pri == $past(st_q.cnt.pri) - `PCM_ONE)
    else $error("count direction with b high did not decrement");
  a_capture_copy: assert property (
    mode.c == pcm_pkg::PCM_C_CAPTURE && ed.c_fall
    |=> cap_pri == $past(st_q.cnt.pri) && cap_sec == $past(st_q.cnt.sec))
    else $error("capture did not copy counters");
  a_gate_diff: assert property (
    mode.c == pcm_pkg::PCM_C_GATE && ed.c_fall
    |=> gate_pri == $past(st_q.cnt.pri) - $past(st_q.prev_pri))
    else $error("primary gate value wrong");
  a_gate_sec_hold: assert property (
    mode.ab != pcm_pkg::PCM_AB_INDEP |=> $stable(gate_sec))
    else $error("secondary gate moved outside independent mode");
  a_idle_hold: assert property (
    !(ed.a_rise | ed.a_fall | ed.b_rise | ed.b_fall) |=> $stable(st_q.cnt.pri))
    else $error("primary counter moved without an edge");

  c_capture_seen: cover property (mode.c == pcm_pkg::PCM_C_CAPTURE && ed.c_fall);
  c_gate_indep: cover property (
    mode.c == pcm_pkg::PCM_C_GATE && mode.ab == pcm_pkg::PCM_AB_INDEP && ed.c_fall);
  c_x4_both: cover property (mode.ab == pcm_pkg::PCM_AB_X4 && ed.a_rise ##[1:50] ed.b_rise);
endmodule // pcm_counter

// [tb/pcm_enc_model.sv]
// encoder or pulse sensor model driving pins a, b and c
`timescale 1ns/100ps
module pcm_enc_model (
  input wire logic clk_sys,
  output logic pin_a,
  output logic pin_b,
  output logic pin_c
);
  // all lines idle low so a reset never sees a held-high pin
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    pin_c = 1'b0;
  end
  task automatic set(input int idx, input logic v);
    @(negedge clk_sys);
    if (idx == 0) pin_a = v;
    else if (idx == 1) pin_b = v;
    else pin_c = v;
    repeat (5) @(negedge clk_sys);
  endtask
  // two pins at once
  // first index is a or b, second is b or c
  task automatic set_pair(input int i0, input logic v0, input int i1, input logic v1);
    @(negedge clk_sys);
    if (i0 == 0) pin_a = v0;
    else pin_b = v0;
    if (i1 == 1) pin_b = v1;
    else pin_c = v1;
    repeat (5) @(negedge clk_sys);
  endtask
endmodule // pcm_enc_model

// [tb/tb_abc_pulse_counter_modes.sv]
// self-checking bench of the pulse counter core
`timescale 1ns/100ps
module tb_abc_pulse_counter_modes;
  localparam logic [31:0] m1 = 32'hffff_ffff;
  logic clk_sys;
  logic rst_n;
  logic pin_a;
  logic pin_b;
  logic pin_c;
  pcm_pkg::pcm_mode_s mode;
  pcm_pkg::pcm_cnt_s counts;
  logic [31:0] cp, cs, gp, gs;
  logic [31:0] e_p, e_s, e_c, e_cp, e_cs, e_gp, e_gs, p_p, p_s;
  int miscompares = 0;
  int num_checks = 0;
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  pcm_enc_model enc (.clk_sys(clk_sys), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));
  pcm_counter DUT (.clk_sys(clk_sys), .rst_n(rst_n), .pin_a(pin_a), .pin_b(pin_b),
    .pin_c(pin_c), .mode(mode), .counts(counts), .cap_pri(cp), .cap_sec(cs),
    .gate_pri(gp), .gate_sec(gs));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic all_chk();
    chk(counts.pri, e_p);
    chk(counts.sec, e_s);
    chk(counts.ccnt, e_c);
    chk(cp, e_cp);
    chk(cs, e_cs);
    chk(gp, e_gp);
    chk(gs, e_gs);
  endtask
  task automatic start(input pcm_pkg::pcm_ab_e ab, input pcm_pkg::pcm_c_e c);
    @(negedge clk_sys);
    rst_n = 1'b0;
    mode.ab = ab;
    mode.c = c;
    {e_p, e_s, e_c, e_cp, e_cs, e_gp, e_gs, p_p, p_s} = '0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    all_chk();
  endtask
  // one pin change with its expected effect, then a full compare
  task automatic put(input int idx, input logic v);
    logic [31:0] dp;
    logic [31:0] ds;
    dp = '0;
    ds = '0;
    if (idx == 0) begin
      case (mode.ab)
        pcm_pkg::PCM_AB_X1: dp = pin_b ? 32'h0 : (v ? m1 : 32'h1);
        pcm_pkg::PCM_AB_X2, pcm_pkg::PCM_AB_X4: dp = (v ^ pin_b) ? m1 : 32'h1;
        pcm_pkg::PCM_AB_CNTDIR: dp = v ? (pin_b ? m1 : 32'h1) : 32'h0;
        default: dp = {31'h0, v};
      endcase
    end else if (idx == 1) begin
      case (mode.ab)
        pcm_pkg::PCM_AB_X4: dp = (v ~^ pin_a) ? m1 : 32'h1;
        pcm_pkg::PCM_AB_SUM: dp = {31'h0, v};
        pcm_pkg::PCM_AB_DIFF: dp = v ? m1 : 32'h0;
        pcm_pkg::PCM_AB_INDEP: ds = {31'h0, v};
        default: dp = '0;
      endcase
    end else if (v && mode.c == pcm_pkg::PCM_C_COUNT) e_c++;
    else if (!v && mode.c == pcm_pkg::PCM_C_CAPTURE) {e_cp, e_cs} = {e_p, e_s};
    else if (!v && mode.c == pcm_pkg::PCM_C_GATE) begin
      e_gp = e_p - p_p;
      if (mode.ab == pcm_pkg::PCM_AB_INDEP) e_gs = e_s - p_s;
      {p_p, p_s} = {e_p, e_s};
    end
    e_p += dp;
    e_s += ds;
    enc.set(idx, v);
    all_chk();
  endtask
  task automatic pulse(input int idx);
    put(idx, 1'b1);
    put(idx, 1'b0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // two turns one way, one back with a capture before its last b edge
  task automatic t_quad();
    pcm_pkg::pcm_ab_e q[3] = '{pcm_pkg::PCM_AB_X1, pcm_pkg::PCM_AB_X2, pcm_pkg::PCM_AB_X4};
    foreach (q[i]) begin
      start(q[i], pcm_pkg::PCM_C_CAPTURE);
      repeat (2) begin
        put(1, 1'b1);
        put(0, 1'b1);
        put(1, 1'b0);
        put(0, 1'b0);
      end
      put(0, 1'b1);
      put(1, 1'b1);
      put(0, 1'b0);
      pulse(2);
      put(1, 1'b0);
    end
  endtask
  // sum, difference and count-direction modes under gate; b first so the difference wraps
  task automatic t_comb();
    pcm_pkg::pcm_ab_e q[3] = '{pcm_pkg::PCM_AB_SUM, pcm_pkg::PCM_AB_DIFF,
      pcm_pkg::PCM_AB_CNTDIR};
    foreach (q[i]) begin
      start(q[i], pcm_pkg::PCM_C_GATE);
      pulse(1);
      pulse(0);
      pulse(2);
      pulse(0);
      put(1, 1'b1);
      pulse(0);
      put(1, 1'b0);
      pulse(2);
    end
  endtask
  task automatic t_indep();
    start(pcm_pkg::PCM_AB_INDEP, pcm_pkg::PCM_C_GATE);
    repeat (3) pulse(1);
    pulse(0);
    pulse(2);
    pulse(1);
    pulse(2);
    // secondary count left over, so a wrong update would show
    @(negedge clk_sys);
    mode.ab = pcm_pkg::PCM_AB_SUM;
    pulse(2);
  endtask
  // coincident edges: both a and b count, capture beside a count
  task automatic t_coin();
    start(pcm_pkg::PCM_AB_SUM, pcm_pkg::PCM_C_CAPTURE);
    enc.set_pair(0, 1'b1, 1, 1'b1);
    e_p = 32'h2;
    all_chk();
    put(0, 1'b0);
    put(1, 1'b0);
    put(2, 1'b1);
    // capture takes the count from before the coincident a edge
    enc.set_pair(0, 1'b1, 2, 1'b0);
    {e_cp, e_cs} = {e_p, e_s};
    e_p += 32'h1;
    all_chk();
    put(0, 1'b0);
  endtask
  // c count, then c ignored with no function
  task automatic t_ccnt();
    start(pcm_pkg::PCM_AB_INDEP, pcm_pkg::PCM_C_COUNT);
    pulse(2);
    pulse(0);
    pulse(2);
    start(pcm_pkg::PCM_AB_X1, pcm_pkg::PCM_C_NONE);
    pulse(2);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    mode = '0;
    t_quad();
    t_comb();
    t_indep();
    t_ccnt();
    t_coin();
    results();
  end
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule // tb_abc_pulse_counter_modes
